/* pwc_cfg.svh */
// constants for the potentiometer wiper control block
`ifndef PWC_CFG_SVH
`define PWC_CFG_SVH

// slave address and instruction byte fields
`define PWC_RW_BIT 0
`define PWC_WR_TYPE_BIT 7
`define PWC_UNIT_EEPROM 3'h0
`define PWC_UNIT_CTRL 3'h2
`define PWC_UNIT_POT 3'h7
`define PWC_SEL_RSVD 2'h3

// highest tap of each array
`define PWC_TOP0 8'h3F
`define PWC_TOP1 8'h63
`define PWC_TOP2 8'hFF

// wiper latch values before recall, stored memory after reset
`define PWC_INIT0 8'h3F
`define PWC_INIT1 8'h00
`define PWC_INIT2 8'hFF
`define PWC_NV_RESET 8'h00

// timing
`define PWC_CLK_MHZ 250
`define PWC_PROG_TIME_US 5000
`define PWC_PROG_CYCLES (`PWC_PROG_TIME_US * `PWC_CLK_MHZ)
`define PWC_POR_TIME_US 50000
`define PWC_POR_CYCLES (`PWC_POR_TIME_US * `PWC_CLK_MHZ)
`define PWC_CNT_W 24

`endif

/* pwc_pkg.sv */
// types for the potentiometer wiper control block
package pwc_pkg;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_ADDR   = 3'h1,
        ST_INSTR  = 3'h2,
        ST_DATA   = 3'h3,
        ST_RD     = 3'h4,
        ST_IGNORE = 3'h5
    } pwc_state_t;

    typedef logic [1:0] pwc_sel_t;

endpackage

/* pwc_wiper_ctrl.sv */
// two-wire slave controlling three digital potentiometer wipers
`timescale 1ns/1ps
`include "pwc_cfg.svh"

module pwc_wiper_ctrl
    import pwc_pkg::*;
#(
    parameter logic [3:0] DEV_TYPE_ID = 4'h5, // arbitrary value
    parameter int PROG_CYCLES = `PWC_PROG_CYCLES,
    parameter int POR_CYCLES = `PWC_POR_CYCLES
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // two-wire link
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // supply monitor
    input wire logic supply_good,
    // status
    output logic prog_busy,
    output logic recall_done,
    // tap switches
    output logic [63:0] tap0_on,
    output logic [99:0] tap1_on,
    output logic [255:0] tap2_on
);

    function automatic logic [7:0] pwc_clamp(input pwc_sel_t s, input logic [7:0] d);
        logic [7:0] top;
        case (s)
            2'h0: top = `PWC_TOP0;
            2'h1: top = `PWC_TOP1;
            default: top = `PWC_TOP2;
        endcase
        pwc_clamp = (d > top) ? top : d;
    endfunction

    function automatic logic [255:0] pwc_onehot(input logic [7:0] v);
        pwc_onehot = 256'h1 << v;
    endfunction

    // link side: bits sampled on the master's clock
    logic link_bit_ff;
    logic link_tgl_ff;

    always_ff @(posedge scl or posedge rst) begin
        if (rst) begin
            link_bit_ff <= 1'b0;
            link_tgl_ff <= 1'b0;
        end else begin
            link_bit_ff <= sda_in;
            link_tgl_ff <= ~link_tgl_ff;
        end
    end

    // synchronisers into the clk domain
    logic scl_s1_ff, scl_s2_ff, scl_s3_ff;
    logic sda_s1_ff, sda_s2_ff, sda_s3_ff;
    logic tgl_s1_ff, tgl_s2_ff, tgl_s3_ff;
    logic pg_s1_ff, pg_s2_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            scl_s1_ff <= 1'b1;
            scl_s2_ff <= 1'b1;
            scl_s3_ff <= 1'b1;
            sda_s1_ff <= 1'b1;
            sda_s2_ff <= 1'b1;
            sda_s3_ff <= 1'b1;
            tgl_s1_ff <= 1'b0;
            tgl_s2_ff <= 1'b0;
            tgl_s3_ff <= 1'b0;
            pg_s1_ff <= 1'b0;
            pg_s2_ff <= 1'b0;
        end else begin
            scl_s1_ff <= scl;
            scl_s2_ff <= scl_s1_ff;
            scl_s3_ff <= scl_s2_ff;
            sda_s1_ff <= sda_in;
            sda_s2_ff <= sda_s1_ff;
            sda_s3_ff <= sda_s2_ff;
            tgl_s1_ff <= link_tgl_ff;
            tgl_s2_ff <= tgl_s1_ff;
            tgl_s3_ff <= tgl_s2_ff;
            pg_s1_ff <= supply_good;
            pg_s2_ff <= pg_s1_ff;
        end
    end

    logic start_ev;
    logic stop_ev;
    logic scl_fall;
    logic bit_ev;

    assign start_ev = scl_s2_ff & scl_s3_ff & sda_s3_ff & ~sda_s2_ff;
    assign stop_ev = scl_s2_ff & scl_s3_ff & ~sda_s3_ff & sda_s2_ff;
    assign scl_fall = scl_s3_ff & ~scl_s2_ff;
    // link bit is stable for a whole scl period once the toggle shows
    assign bit_ev = tgl_s2_ff ^ tgl_s3_ff;

    // protocol state
    pwc_state_t state_ff;
    logic [3:0] cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] rd_ff;
    pwc_sel_t sel_ff;
    logic wr_type_ff;
    logic pend_ff;
    logic busy_ff;
    logic recalled_ff;
    logic [7:0] latch_ff [3];
    logic [7:0] nv_ff [3];

    logic ack_ok;
    logic wr_go;

    always_comb begin
        case (state_ff)
            ST_ADDR: ack_ok = (shift_ff[7:4] == DEV_TYPE_ID)
                    && (shift_ff[3:1] == `PWC_UNIT_POT)
                    && !busy_ff && recalled_ff;
            ST_INSTR: ack_ok = (shift_ff[1:0] != `PWC_SEL_RSVD);
            ST_DATA: ack_ok = 1'b1;
            default: ack_ok = 1'b0;
        endcase
    end

    assign wr_go = bit_ev && (cnt_ff == 4'h8) && (state_ff == ST_DATA);

    // byte sequencing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            rd_ff <= 8'h00;
            sel_ff <= 2'h0;
            wr_type_ff <= 1'b0;
        end else if (start_ev) begin
            state_ff <= ST_ADDR;
            cnt_ff <= 4'h0;
        end else if (stop_ev) begin
            state_ff <= ST_IDLE;
            cnt_ff <= 4'h0;
        end else if (bit_ev && state_ff != ST_IDLE) begin
            if (cnt_ff != 4'h8) begin
                cnt_ff <= cnt_ff + 4'h1;
                shift_ff <= {shift_ff[6:0], link_bit_ff};
                rd_ff <= {rd_ff[6:0], 1'b0};
            end else begin
                cnt_ff <= 4'h0;
                case (state_ff)
                    ST_ADDR: begin
                        if (!ack_ok) begin
                            state_ff <= ST_IGNORE;
                        end else if (shift_ff[`PWC_RW_BIT]) begin
                            state_ff <= ST_RD;
                            rd_ff <= latch_ff[sel_ff];
                        end else begin
                            state_ff <= ST_INSTR;
                        end
                    end
                    ST_INSTR: begin
                        if (ack_ok) begin
                            state_ff <= ST_DATA;
                            sel_ff <= shift_ff[1:0];
                            wr_type_ff <= shift_ff[`PWC_WR_TYPE_BIT];
                        end else begin
                            state_ff <= ST_IGNORE;
                        end
                    end
                    ST_RD: begin
                        // master acknowledge repeats the same wiper value
                        if (!link_bit_ff) begin
                            rd_ff <= latch_ff[sel_ff];
                        end else begin
                            state_ff <= ST_IGNORE;
                        end
                    end
                    default: state_ff <= ST_IGNORE;
                endcase
            end
        end
    end

    // open-drain data drive, changed after scl falls or at start and stop
    logic sda_oe_ff;
    logic sda_out_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_oe_ff <= 1'b0;
        end else if (start_ev || stop_ev) begin
            sda_oe_ff <= 1'b0;
        end else if (scl_fall) begin
            if (state_ff == ST_RD && cnt_ff != 4'h8) begin
                sda_oe_ff <= ~rd_ff[7];
            end else begin
                sda_oe_ff <= (cnt_ff == 4'h8) && ack_ok;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sda_out_ff <= 1'b0;
        end else begin
            sda_out_ff <= 1'b0;
        end
    end

    // nonvolatile programming busy time
    logic [`PWC_CNT_W-1:0] busy_cnt_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pend_ff <= 1'b0;
        end else if (wr_go && wr_type_ff) begin
            pend_ff <= 1'b1;
        end else if (start_ev || stop_ev) begin
            pend_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_cnt_ff <= '0;
            busy_ff <= 1'b0;
        end else if (stop_ev && pend_ff) begin
            busy_cnt_ff <= `PWC_CNT_W'(PROG_CYCLES);
            busy_ff <= 1'b1;
        end else if (busy_cnt_ff != '0) begin
            busy_cnt_ff <= busy_cnt_ff - `PWC_CNT_W'(1);
            busy_ff <= (busy_cnt_ff != `PWC_CNT_W'(1));
        end
    end

    // power-on recall timing
    logic [`PWC_CNT_W-1:0] por_cnt_ff;
    logic recall_go;

    assign recall_go = pg_s2_ff && !recalled_ff && (por_cnt_ff == `PWC_CNT_W'(POR_CYCLES));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            por_cnt_ff <= '0;
            recalled_ff <= 1'b0;
        end else if (!pg_s2_ff) begin
            por_cnt_ff <= '0;
            recalled_ff <= 1'b0;
        end else if (recall_go) begin
            recalled_ff <= 1'b1;
        end else if (!recalled_ff) begin
            por_cnt_ff <= por_cnt_ff + `PWC_CNT_W'(1);
        end
    end

    // wiper latches and stored wiper memory
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            latch_ff[0] <= `PWC_INIT0;
            latch_ff[1] <= `PWC_INIT1;
            latch_ff[2] <= `PWC_INIT2;
            nv_ff[0] <= `PWC_NV_RESET;
            nv_ff[1] <= `PWC_NV_RESET;
            nv_ff[2] <= `PWC_NV_RESET;
        end else if (!pg_s2_ff) begin
            latch_ff[0] <= `PWC_INIT0;
            latch_ff[1] <= `PWC_INIT1;
            latch_ff[2] <= `PWC_INIT2;
        end else if (recall_go) begin
            for (int i = 0; i < 3; i++) begin
                latch_ff[i] <= nv_ff[i];
            end
        end else if (wr_go) begin
            latch_ff[sel_ff] <= pwc_clamp(sel_ff, shift_ff);
            if (wr_type_ff) begin
                nv_ff[sel_ff] <= pwc_clamp(sel_ff, shift_ff);
            end
        end
    end

    // tap switch decode, old and new overlap for one cycle
    logic [7:0] shown_ff [3];
    logic [255:0] taps_ff [3];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            shown_ff[0] <= `PWC_INIT0;
            shown_ff[1] <= `PWC_INIT1;
            shown_ff[2] <= `PWC_INIT2;
            taps_ff[0] <= pwc_onehot(`PWC_INIT0);
            taps_ff[1] <= pwc_onehot(`PWC_INIT1);
            taps_ff[2] <= pwc_onehot(`PWC_INIT2);
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (latch_ff[i] != shown_ff[i]) begin
                    taps_ff[i] <= pwc_onehot(latch_ff[i]) | pwc_onehot(shown_ff[i]);
                    shown_ff[i] <= latch_ff[i];
                end else begin
                    taps_ff[i] <= pwc_onehot(shown_ff[i]);
                end
            end
        end
    end

    assign sda_oe = sda_oe_ff;
    assign sda_out = sda_out_ff;
    assign prog_busy = busy_ff;
    assign recall_done = recalled_ff;
    assign tap0_on = taps_ff[0][63:0];
    assign tap1_on = taps_ff[1][99:0];
    assign tap2_on = taps_ff[2][255:0];

endmodule

/* pwc_wiper_ctrl_assertions.sv */
// assertions on the wiper control ports
`timescale 1ns/1ps
module pwc_wiper_ctrl_assertions #(
    parameter int PROG_CYCLES = 200,
    parameter int POR_CYCLES = 50
) (
    // system
    input wire logic clk,
    input wire logic rst,
    // link
    input wire logic scl,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    // status
    input wire logic supply_good,
    input wire logic prog_busy,
    input wire logic recall_done,
    // taps
    input wire logic [63:0] tap0_on,
    input wire logic [99:0] tap1_on,
    input wire logic [255:0] tap2_on
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    int busy_n_ff;
    int good_n_ff;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_n_ff <= 0;
            good_n_ff <= 0;
        end else begin
            busy_n_ff <= prog_busy ? busy_n_ff + 1 : 0;
            good_n_ff <= supply_good ? good_n_ff + 1 : 0;
        end
    end
    tap_count_a:
        assert property ($countones(tap0_on) inside {[1:2]}
            && $countones(tap2_on) inside {[1:2]})
        else $error("tap count bad");
    make_break_a:
        assert property ($countones(tap1_on) == 2
            |=> $onehot(tap1_on) && (tap1_on & ~$past(tap1_on)) == 0)
        else $error("tap1 overlap bad");
    step_order_a:
        assert property (supply_good && recall_done && $past(recall_done)
            && $onehot($past(tap2_on)) && tap2_on != $past(tap2_on)
            |-> (tap2_on & $past(tap2_on)) != 0)
        else $error("tap2 broke first");
    busy_len_a:
        assert property ($fell(prog_busy) |-> busy_n_ff == PROG_CYCLES)
        else $error("busy length bad");
    busy_quiet_a:
        assert property (prog_busy |-> !sda_oe)
        else $error("ack while busy");
    recall_quiet_a:
        assert property (!recall_done |-> !sda_oe)
        else $error("ack before recall");
    recall_delay_a:
        assert property ($rose(recall_done) |-> good_n_ff >= POR_CYCLES)
        else $error("recall too early");
    init_taps_a:
        assert property (!recall_done [*3]
            |-> tap0_on[63] && tap1_on[0] && tap2_on[255])
        else $error("initial taps bad");
    cover property ($rose(prog_busy));
    cover property ($rose(recall_done));
    cover property ($countones(tap1_on) == 2);
endmodule

/* pwc_master_model.sv */
// two-wire bus master driving the link
`timescale 1ns/1ps
module pwc_master_model (
    // link
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    initial begin
        scl = 1;
        sda_low = 0;
    end
    task automatic bit_io(input logic v, output logic s);
        sda_low = !v;
        #8 scl = 1;
        s = sda;
        #16 scl = 0;
        #8;
    endtask
    task automatic start();
        sda_low = 0;
        #8 scl = 1;
        #8 sda_low = 1;
        #8 scl = 0;
        #8;
    endtask
    task automatic stop();
        sda_low = 1;
        #8 scl = 1;
        #8 sda_low = 0;
        #16;
    endtask
    // msb first, ack slot released
    task automatic tx(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, s);
        ack = !s;
    endtask
    task automatic rx(output logic [7:0] d, input logic mack);
        logic s;
        for (int i = 0; i < 8; i++) begin
            bit_io(1'b1, s);
            d = {d[6:0], s};
        end
        bit_io(!mack, s);
    endtask
endmodule

/* pwc_wiper_ctrl_tb.sv */
// self-checking bench for the wiper control block
`timescale 1ns/1ps
module pwc_wiper_ctrl_tb;
    localparam logic [3:0] ID = 4'h5; // arbitrary value
    localparam logic [7:0] AW = {ID, 4'hE};
    localparam int POR = 50;
    logic clk = 0;
    logic rst = 1;
    logic supply_good = 0;
    logic scl, sda_low, sda, sda_out, sda_oe, prog_busy, recall_done, a0, a1, a2;
    logic [63:0] tap0_on;
    logic [99:0] tap1_on;
    logic [255:0] tap2_on;
    logic [7:0] d;
    int fails = 0;
    int total_checks = 0;
    int n;
    // pulled-up wire, device drives its output value while enabled
    assign sda = !sda_low && !(sda_oe && !sda_out);
    initial begin
        forever #2 clk = ~clk;
    end
    pwc_wiper_ctrl #(.DEV_TYPE_ID(ID), .PROG_CYCLES(200), .POR_CYCLES(POR)) dut_u (
        .clk(clk), .rst(rst), .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .supply_good(supply_good), .prog_busy(prog_busy), .recall_done(recall_done),
        .tap0_on(tap0_on), .tap1_on(tap1_on), .tap2_on(tap2_on));
    pwc_master_model mst_u (.scl(scl), .sda_low(sda_low), .sda(sda));
    task automatic chk(input string nm, input logic [255:0] e, g);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s exp %0h got %0h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [7:0] a, i, v);
        mst_u.start();
        mst_u.tx(a, a0);
        mst_u.tx(i, a1);
        mst_u.tx(v, a2);
        mst_u.stop();
        repeat (4) @(negedge clk);
    endtask
    task automatic rd(input logic [7:0] i);
        mst_u.start();
        mst_u.tx(AW, a0);
        mst_u.tx(i, a1);
        mst_u.start();
        mst_u.tx(AW | 8'h01, a2);
        mst_u.rx(d, 1'b0);
        mst_u.stop();
        @(negedge clk);
    endtask
    task automatic power_up();
        supply_good = 1;
        n = 0;
        while (recall_done !== 1'b1 && n < 500) begin
            @(negedge clk);
            n++;
        end
        // taps pass the two-hot step before settling
        repeat (2) @(negedge clk);
    endtask
    task automatic report_and_stop();
        $display("checks %0d fails %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (6) @(negedge clk);
        rst = 0;
        chk("init", 3'h7, {tap0_on[63], tap1_on[0], tap2_on[255]});
        wr(AW, 8'h00, 8'h10);
        chk("ack early", 0, a0);
        power_up();
        chk("recall wait", 1, n >= POR);
        chk("recall", 3'h7, {tap0_on[0], tap1_on[0], tap2_on[0]});
        wr({ID, 4'h0}, 8'h00, 8'h10);
        chk("ack array", 0, a0);
        wr({ID, 4'h4}, 8'h00, 8'h10);
        chk("ack ctrl", 0, a0);
        wr({~ID, 4'hE}, 8'h00, 8'h10);
        chk("ack type", 0, a0);
        wr(AW, 8'h03, 8'h10);
        chk("ack rsvd", 2'h2, {a0, a1});
        wr(AW, 8'h00, 8'h50);
        chk("ack vol", 4'h7, {prog_busy, a0, a1, a2});
        chk("tap0", 256'h1 << 63, tap0_on);
        rd(8'h80);
        chk("read pot0", 9'h03F, {prog_busy, d});
        wr(AW, 8'h81, 8'hFF);
        chk("busy", 1, prog_busy);
        chk("tap1", 256'h1 << 99, tap1_on);
        wr(AW, 8'h02, 8'h5A);
        chk("poll busy", 2'h1, {a0, tap2_on[0]});
        n = 0;
        while (prog_busy !== 1'b0 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        wr(AW, 8'h02, 8'hA5);
        chk("poll idle", 1, a0);
        rd(8'h02);
        chk("read pot2", 8'hA5, d);
        rd(8'h01);
        chk("read pot1", 8'h63, d);
        supply_good = 0;
        repeat (20) @(negedge clk);
        chk("drop", 2'h2, {tap2_on[255], recall_done});
        power_up();
        chk("cycle", 3'h7, {tap0_on[0], tap1_on[99], tap2_on[0]});
        report_and_stop();
    end
endmodule
bind pwc_wiper_ctrl pwc_wiper_ctrl_assertions #(
    .PROG_CYCLES(PROG_CYCLES), .POR_CYCLES(POR_CYCLES)) chk_u (
    .clk(clk), .rst(rst), .scl(scl), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe(sda_oe), .supply_good(supply_good), .prog_busy(prog_busy),
    .recall_done(recall_done), .tap0_on(tap0_on), .tap1_on(tap1_on), .tap2_on(tap2_on));
